// >>> gpel_pkg.sv
// Purpose: Shared constants and carrier types for the general-purpose event logic
// Assumes: 8-bit byte address, 16-bit register data on the plain register port
// Notes: Registers sit at their byte offsets; 8-bit ones use the low data bits
package gpel_pkg;

	// ----------------------------------------
	// Register port geometry
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_BRIDGE_EXT = 8'hA6;
	localparam logic [7:0] OFF_PM_DATA = 8'hA7;
	localparam logic [7:0] OFF_EVT_STATUS = 8'hA8;
	localparam logic [7:0] OFF_EVT_ENABLE = 8'hAA;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_BUS_PWR_CLK = 7;
	localparam int BIT_SEC_BUS_OFF = 6;
	localparam int BIT_VIDEO_CHG = 15;
	localparam int BIT_POWER_CHG = 11;
	localparam int BIT_VPP12_CHG = 8;
	localparam int BIT_INPUT_LO = 0;
	localparam int NUM_INPUTS = 5;

	// ----------------------------------------
	// Fixed values and reset values
	// ----------------------------------------
	localparam logic [7:0] BRIDGE_EXT_VALUE = 8'hC0;
	localparam logic [7:0] PM_DATA_VALUE = 8'h00;
	localparam logic [15:0] EVT_MASK = 16'h891F;
	localparam logic [15:0] EVT_STATUS_RST = 16'h0000;
	localparam logic [15:0] EVT_ENABLE_RST = 16'h0000;
	localparam logic [15:0] RDATA_RST = 16'h0000;
	localparam logic [1:0] VPP_SEL_12V = 2'h2;

	// ----------------------------------------
	// Change detector lanes
	// ----------------------------------------
	localparam int DET_W = 11;
	localparam int LANE_VIDEO = 0;
	localparam int LANE_VCC_LO = 1;
	localparam int LANE_VPP_HI = 4;
	localparam int LANE_VPP12 = 5;
	localparam int LANE_INPUT_LO = 6;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} gpel_bus_req_t;

	typedef struct packed {
		logic video_enable;
		logic [1:0] vcc_sel;
		logic [1:0] vpp_sel;
	} gpel_socket_t;

endpackage

// >>> gpel_change_detect.sv
// Purpose: Per-lane level change detector for event sources
// Assumes: Inputs already synchronous to the clock
// Notes: First sample after reset only primes the history, never flags
`timescale 1ns/1ps
`default_nettype none
module gpel_change_detect
	import gpel_pkg::*;
#(
	parameter int W = DET_W
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] level_in,
	output logic [W-1:0] change,
	output logic ready
);

	logic [W-1:0] in_q_ff;
	logic [W-1:0] prev_ff;
	logic primed_ff;
	logic ready_ff;

	// Two samples needed before a compare means anything
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			primed_ff <= 1'b0;
			ready_ff <= 1'b0;
		end else begin
			primed_ff <= 1'b1;
			ready_ff <= primed_ff;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_lane
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					in_q_ff[i] <= 1'b0;
					prev_ff[i] <= 1'b0;
				end else begin
					in_q_ff[i] <= level_in[i];
					prev_ff[i] <= in_q_ff[i];
				end
			end
			assign change[i] = ready_ff & (in_q_ff[i] ^ prev_ff[i]);
		end
	endgenerate

	assign ready = ready_ff;

endmodule // gpel_change_detect
`default_nettype wire

// >>> gpel_event_logic.sv
// Purpose: General-purpose event status, enable and event output, plus two fixed bytes
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Status bits are write-one-to-clear; a new event beats a clear
//
// How it works
// - Bridge extension byte bit 7 always reads one.
// - Bridge extension byte bit 6 always reads one.
// - Reserved bits of extension, status and enable read zero.
// - Power management data byte is read-only and always zero.
// - Writing one clears a status bit and its event; zero leaves it.
// - Status bits set on events regardless of enable bits.
// - Status bit 15 sets when socket video enable changes.
// - Status bit 11 sets when card supply or programming voltage changes.
// - Status bit 8 sets when programming voltage goes to or from 12 V.
// - Status bits 4..0 set on level changes of the five terminals.
// - An event source raises the output only while its enable is set.
// - Event output stays asserted until the status bit or its enable bit is cleared.
// - Event reaches the pin only if a terminal carries event signaling.
// - Terminal change events only when configured as that general input.
// - Enable and status registers reset to all zeros.
`timescale 1ns/1ps
`default_nettype none
module gpel_event_logic
	import gpel_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire gpel_bus_req_t bus_req,
	output logic [DATA_W-1:0] bus_rdata,
	input wire gpel_socket_t socket_ctrl,
	input wire logic [NUM_INPUTS-1:0] general_input,
	input wire logic [NUM_INPUTS-1:0] general_input_cfg,
	input wire logic event_pin_cfg,
	output logic general_event_output,
	output logic general_event_pin
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync_ff;
	logic rst_n_sync;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	assign rst_n_sync = rst_sync_ff[1];

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction

	logic wr_status;
	logic wr_enable;
	logic rd_ext;
	logic rd_pm;
	logic rd_status;
	logic rd_enable;

	assign wr_status = bus_req.wr & reg_hit(bus_req.addr, OFF_EVT_STATUS);
	assign wr_enable = bus_req.wr & reg_hit(bus_req.addr, OFF_EVT_ENABLE);
	assign rd_ext = bus_req.rd & reg_hit(bus_req.addr, OFF_BRIDGE_EXT);
	assign rd_pm = bus_req.rd & reg_hit(bus_req.addr, OFF_PM_DATA);
	assign rd_status = bus_req.rd & reg_hit(bus_req.addr, OFF_EVT_STATUS);
	assign rd_enable = bus_req.rd & reg_hit(bus_req.addr, OFF_EVT_ENABLE);

	// ----------------------------------------
	// Event sources
	// ----------------------------------------
	logic vpp_is_12v;
	logic [DET_W-1:0] det_level;
	logic [DET_W-1:0] det_change;
	logic det_ready;

	// track the 12 V request as its own level
	assign vpp_is_12v = socket_ctrl.vpp_sel == VPP_SEL_12V;
	assign det_level = {general_input, vpp_is_12v, socket_ctrl.vpp_sel,
		socket_ctrl.vcc_sel, socket_ctrl.video_enable};

	gpel_change_detect #(
		.W(DET_W)
	) u_detect (
		.ref_clk(ref_clk),
		.rst_n(rst_n_sync),
		.level_in(det_level),
		.change(det_change),
		.ready(det_ready)
	);

	logic [15:0] set_vec;
	logic [15:0] clr_vec;
	logic [NUM_INPUTS-1:0] input_events;

	// only terminals set up as general inputs count
	assign input_events = det_change[LANE_INPUT_LO +: NUM_INPUTS] & general_input_cfg;

	// sources never look at the enable bits
	always_comb begin
		set_vec = 16'h0000;
		set_vec[BIT_VIDEO_CHG] = det_change[LANE_VIDEO];
		set_vec[BIT_POWER_CHG] = |det_change[LANE_VPP_HI:LANE_VCC_LO];
		// 12 V request entered or left
		set_vec[BIT_VPP12_CHG] = det_change[LANE_VPP12];
		set_vec[BIT_INPUT_LO +: NUM_INPUTS] = input_events;
	end

	assign clr_vec = wr_status ? (bus_req.wdata & EVT_MASK) : 16'h0000;

	// ----------------------------------------
	// Status and enable registers
	// ----------------------------------------
	logic [15:0] status_ff;
	logic [15:0] enable_ff;
	logic [15:0] nxt_status;
	logic [15:0] nxt_enable;

	// a fresh event wins over a same-cycle clear
	assign nxt_status = ((status_ff & ~clr_vec) | set_vec) & EVT_MASK;
	assign nxt_enable = wr_enable ? (bus_req.wdata & EVT_MASK) : enable_ff;

	// nothing pending or enabled after reset
	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			status_ff <= EVT_STATUS_RST;
			enable_ff <= EVT_ENABLE_RST;
		end else begin
			status_ff <= nxt_status;
			enable_ff <= nxt_enable;
		end
	end

	// ----------------------------------------
	// Event output
	// ----------------------------------------
	logic gpe_ff;
	logic pin_ff;
	logic nxt_gpe;
	logic nxt_pin;

	// gated per source by its enable
	// held as long as the status bit and its enable bit both stand
	assign nxt_gpe = |(status_ff & enable_ff);
	// no pin assigned, no external event
	assign nxt_pin = nxt_gpe & event_pin_cfg;

	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			gpe_ff <= 1'b0;
			pin_ff <= 1'b0;
		end else begin
			gpe_ff <= nxt_gpe;
			pin_ff <= nxt_pin;
		end
	end

	assign general_event_output = gpe_ff;
	assign general_event_pin = pin_ff;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [DATA_W-1:0] nxt_rdata;
	logic [DATA_W-1:0] rdata_ff;
	logic [7:0] ext_byte;

	// bus power and clock control capable
	assign ext_byte = BRIDGE_EXT_VALUE;

	// reserved bits and unmapped offsets read zero
	// power management data is a constant zero
	always_comb begin
		nxt_rdata = RDATA_RST;
		if (rd_ext) begin
			nxt_rdata = {8'h00, ext_byte};
		end else if (rd_pm) begin
			nxt_rdata = {8'h00, PM_DATA_VALUE};
		end else if (rd_status) begin
			nxt_rdata = status_ff & EVT_MASK;
		end else if (rd_enable) begin
			nxt_rdata = enable_ff & EVT_MASK;
		end
	end

	// Data only valid the cycle after a read, zero otherwise
	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			rdata_ff <= RDATA_RST;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign bus_rdata = rdata_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n_sync);

	logic [15:0] past_clr_ff;
	logic [15:0] past_set_ff;

	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			past_clr_ff <= 16'h0000;
			past_set_ff <= 16'h0000;
		end else begin
			past_clr_ff <= clr_vec;
			past_set_ff <= set_vec;
		end
	end

	ext_byte_read_a: assert property (
		rd_ext |=> bus_rdata == 16'h00C0)
		else $error("bridge extension byte wrong");

	pm_data_read_a: assert property (
		rd_pm |=> bus_rdata == 16'h0000)
		else $error("power management data not zero");

	reserved_zero_a: assert property (
		(rd_status || rd_enable) |=> (bus_rdata & 16'h76E0) == 16'h0000)
		else $error("reserved event bits read nonzero");

	status_clear_a: assert property (
		wr_status |=> (status_ff & past_clr_ff & ~past_set_ff) == 16'h0000)
		else $error("status bit not cleared by write one");

	status_set_a: assert property (
		(set_vec != 16'h0000) |=> (status_ff & past_set_ff) == past_set_ff)
		else $error("event did not set status");

	video_change_a: assert property (
		(det_ready && $changed(socket_ctrl.video_enable)) |-> ##2 status_ff[15])
		else $error("video enable change missed");

	power_change_a: assert property (
		(det_ready && ($changed(socket_ctrl.vcc_sel) || $changed(socket_ctrl.vpp_sel)))
		|-> ##2 status_ff[11])
		else $error("socket power change missed");

	vpp12_change_a: assert property (
		(det_ready && $changed(vpp_is_12v)) |-> ##2 status_ff[8])
		else $error("12 V request change missed");

	input_change_a: assert property (
		(det_ready && ($changed(general_input) != 1'b0) && general_input_cfg == 5'h1F)
		|-> ##2 (status_ff[4:0] != 5'h00))
		else $error("terminal change missed");

	unconfig_input_a: assert property (
		(general_input_cfg == 5'h00 && status_ff[4:0] == 5'h00) |=> status_ff[4:0] == 5'h00)
		else $error("unconfigured terminal set status");

	event_drive_a: assert property (
		((status_ff & enable_ff) != 16'h0000) |=> general_event_output)
		else $error("enabled event not driven");

	event_masked_a: assert property (
		(enable_ff == 16'h0000) [*2] |-> !general_event_output)
		else $error("event driven with no enable");

	event_hold_a: assert property (
		(general_event_output && !wr_status && !wr_enable && $stable(status_ff)
		&& $stable(enable_ff)) |=> general_event_output)
		else $error("event dropped before clear");

	pin_gate_a: assert property (
		!event_pin_cfg |=> !general_event_pin)
		else $error("event on pin without event terminal");

	reset_state_a: assert property (
		$rose(rst_n_sync) |-> (status_ff == 16'h0000 && enable_ff == 16'h0000))
		else $error("event registers not cleared by reset");

	video_event_c: cover property (
		enable_ff[15] && det_change[LANE_VIDEO] ##2 general_event_output);

	clear_event_c: cover property (
		general_event_output && wr_status ##2 !general_event_output);

	set_beats_clear_c: cover property (
		(clr_vec & set_vec) != 16'h0000);

	pin_event_c: cover property (
		$rose(general_event_pin));

endmodule // gpel_event_logic
`default_nettype wire

// >>> gpel_host_model.sv
// Purpose: Host software model on the register port
// Assumes: Strobes one cycle long, read data one cycle after
// Notes: Idle address and data show inverted values, never the old ones
`timescale 1ns/1ps
`default_nettype none
module gpel_host_model
	import gpel_pkg::*;
(
	input wire logic ref_clk,
	output var gpel_bus_req_t bus_req,
	input wire logic [DATA_W-1:0] bus_rdata
);
	initial begin
		bus_req = '0;
	end

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 16'h5A5A, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req <= '{addr: ~a, wdata: 16'hA5A5, wr: 1'b0, rd: 1'b0};
		// Data stands only in this cycle
		@(negedge ref_clk);
		d = bus_rdata;
		// Return on a rising edge so callers drive there
		@(posedge ref_clk);
	endtask
endmodule // gpel_host_model
`default_nettype wire

// >>> gpel_event_logic_bench.sv
// Purpose: Self-checking bench for the event logic
// Assumes: Host model drives the register port
// Notes: Event waits of four cycles cover the three-cycle event path
`timescale 1ns/1ps
`default_nettype none
module gpel_event_logic_bench
	import gpel_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	gpel_bus_req_t bus_req;
	logic [DATA_W-1:0] bus_rdata;
	gpel_socket_t socket_ctrl = '0;
	logic [NUM_INPUTS-1:0] general_input = '0;
	logic [NUM_INPUTS-1:0] general_input_cfg = '0;
	logic event_pin_cfg = 1'b0;
	logic general_event_output;
	logic general_event_pin;
	int fails = 0;
	int n_checks = 0;

	always #50 ref_clk = ~ref_clk;

	gpel_event_logic dut_u (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata),
		.socket_ctrl(socket_ctrl),
		.general_input(general_input),
		.general_input_cfg(general_input_cfg),
		.event_pin_cfg(event_pin_cfg),
		.general_event_output(general_event_output),
		.general_event_pin(general_event_pin)
	);

	gpel_host_model host_u (
		.ref_clk(ref_clk),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		host_u.rd_reg(a, d);
		check(what, d, exp);
	endtask

	// Pin in bit 1, output in bit 0
	task automatic evt_chk(input logic [1:0] exp);
		@(negedge ref_clk);
		check("event pin/out", {14'h0, general_event_pin, general_event_output}, {14'h0, exp});
		@(posedge ref_clk);
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_fixed;
		rd_chk("status", OFF_EVT_STATUS, 16'h0000);
		rd_chk("enable", OFF_EVT_ENABLE, 16'h0000);
		host_u.wr_reg(OFF_BRIDGE_EXT, 16'hFFFF);
		host_u.wr_reg(OFF_PM_DATA, 16'hFFFF);
		rd_chk("bridge ext", OFF_BRIDGE_EXT, 16'h00C0);
		rd_chk("pm data", OFF_PM_DATA, 16'h0000);
		rd_chk("unmapped", 8'hA9, 16'h0000);
		host_u.wr_reg(OFF_EVT_STATUS, 16'hFFFF);
		rd_chk("status idle", OFF_EVT_STATUS, 16'h0000);
		host_u.wr_reg(OFF_EVT_ENABLE, 16'hFFFF);
		rd_chk("enable mask", OFF_EVT_ENABLE, 16'h891F);
		host_u.wr_reg(OFF_EVT_ENABLE, 16'h0000);
		evt_chk(2'b00);
	endtask

	task automatic t_inputs;
		general_input_cfg <= 5'h1F;
		cyc(4);
		general_input <= 5'h1F;
		cyc(4);
		evt_chk(2'b00);
		rd_chk("rise status", OFF_EVT_STATUS, 16'h001F);
		host_u.wr_reg(OFF_EVT_STATUS, 16'h001F);
		general_input <= 5'h00;
		cyc(4);
		rd_chk("fall status", OFF_EVT_STATUS, 16'h001F);
		host_u.wr_reg(OFF_EVT_ENABLE, 16'h001F);
		cyc(2);
		evt_chk(2'b01);
		event_pin_cfg <= 1'b1;
		cyc(2);
		evt_chk(2'b11);
		host_u.wr_reg(OFF_EVT_STATUS, 16'h0000);
		rd_chk("zero write", OFF_EVT_STATUS, 16'h001F);
		host_u.wr_reg(OFF_EVT_STATUS, 16'h000F);
		cyc(2);
		evt_chk(2'b11);
		rd_chk("part clear", OFF_EVT_STATUS, 16'h0010);
		host_u.wr_reg(OFF_EVT_STATUS, 16'h0010);
		cyc(2);
		evt_chk(2'b00);
	endtask

	task automatic t_cfg_off;
		general_input_cfg <= 5'h00;
		general_input <= 5'h0A;
		cyc(4);
		rd_chk("cfg none", OFF_EVT_STATUS, 16'h0000);
		general_input_cfg <= 5'h15;
		cyc(4);
		host_u.wr_reg(OFF_EVT_STATUS, 16'hFFFF);
		general_input <= 5'h1F;
		cyc(4);
		rd_chk("cfg gated", OFF_EVT_STATUS, 16'h0015);
		host_u.wr_reg(OFF_EVT_STATUS, 16'h0015);
		host_u.wr_reg(OFF_EVT_ENABLE, 16'h0000);
	endtask

	task automatic t_socket;
		host_u.wr_reg(OFF_EVT_ENABLE, 16'h8900);
		socket_ctrl.video_enable <= 1'b1;
		cyc(4);
		evt_chk(2'b11);
		rd_chk("video", OFF_EVT_STATUS, 16'h8000);
		host_u.wr_reg(OFF_EVT_STATUS, 16'h8000);
		socket_ctrl.vcc_sel <= 2'h1;
		cyc(4);
		rd_chk("vcc", OFF_EVT_STATUS, 16'h0800);
		host_u.wr_reg(OFF_EVT_STATUS, 16'h0800);
		socket_ctrl.vpp_sel <= VPP_SEL_12V;
		cyc(4);
		rd_chk("to 12v", OFF_EVT_STATUS, 16'h0900);
		host_u.wr_reg(OFF_EVT_STATUS, 16'h0900);
		socket_ctrl.vpp_sel <= 2'h1;
		cyc(4);
		rd_chk("from 12v", OFF_EVT_STATUS, 16'h0900);
		host_u.wr_reg(OFF_EVT_STATUS, 16'h0900);
		socket_ctrl.vpp_sel <= 2'h3;
		cyc(4);
		rd_chk("not 12v", OFF_EVT_STATUS, 16'h0800);
		host_u.wr_reg(OFF_EVT_STATUS, 16'h0800);
		cyc(2);
		evt_chk(2'b00);
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		cyc(3);
		rstn <= 1'b1;
		// Two flops of reset release plus detector priming
		cyc(6);
		t_fixed();
		t_inputs();
		t_cfg_off();
		t_socket();
		close_out();
	end

	initial begin
		#1000000;
		fails++;
		close_out();
	end
endmodule // gpel_event_logic_bench
`default_nettype wire
